// ---- lfs_params.svh ----
// Constants for the line-feed setpoint register bank.
`ifndef LFS_PARAMS_SVH
`define LFS_PARAMS_SVH

`define LFS_ADDR_W 8
`define LFS_DATA_W 8

`define LFS_OFS_MANUAL_CTL 8'h43
`define LFS_OFS_LINE_STATUS 8'h44
`define LFS_OFS_RT_DEBOUNCE 8'h46
`define LFS_OFS_FEED_CURRENT 8'h47
`define LFS_OFS_ON_HOOK 8'h48
`define LFS_OFS_COMMON_MODE 8'h49
`define LFS_OFS_HIGH_BATTERY 8'h4A
`define LFS_OFS_IRQ_STATUS 8'h50
`define LFS_OFS_IRQ_MASK 8'h51

`define LFS_RST_RT_DEBOUNCE 7'h0A
`define LFS_RST_FEED_CURRENT 3'h0
`define LFS_RST_POLARITY 1'h0
`define LFS_RST_ON_HOOK 6'h20
`define LFS_RST_COMMON_MODE 6'h02
`define LFS_RST_HIGH_BATTERY 6'h32
`define LFS_RST_MANUAL 1'h0
`define LFS_RST_IRQ 2'h0

`define LFS_DEBOUNCE_W 7
`define LFS_CURRENT_W 3
`define LFS_VOLT_W 6
`define LFS_IRQ_W 2

`define LFS_BIT_POLARITY 6
`define LFS_BIT_MANUAL_CM 6
`define LFS_BIT_MANUAL_DIFF 5
`define LFS_BIT_RING_TRIP 1
`define LFS_IRQ_DETECT 0
`define LFS_IRQ_RELEASE 1

`define LFS_CLK_PERIOD_NS 10
`define LFS_DEBOUNCE_STEP_NS 1250000
`define LFS_DEBOUNCE_STEP_CYCLES ((`LFS_DEBOUNCE_STEP_NS + `LFS_CLK_PERIOD_NS - 1) / `LFS_CLK_PERIOD_NS)

`endif

// ---- lfs_pkg.sv ----
// Types shared by the line-feed setpoint register bank.
package lfs_pkg;

    typedef enum logic [2:0] {
        LFS_LS_OPEN,
        LFS_LS_FWD_ACTIVE,
        LFS_LS_FWD_ON_HOOK,
        LFS_LS_REV_ACTIVE,
        LFS_LS_REV_ON_HOOK
    } lfs_line_state_t;

    typedef enum logic {
        LFS_DB_STEADY,
        LFS_DB_TIMING
    } lfs_db_state_t;

endpackage

// ---- lfs_dbnc_if.sv ----
// Interface between the register bank and the ring-trip debounce filter.
`timescale 1ns/100ps
`include "lfs_params.svh"
interface lfs_dbnc_if;
    logic tick;
    logic sample;
    logic [`LFS_DEBOUNCE_W-1:0] interval_code;
    logic filtered;

    modport bank (output tick, output sample, output interval_code, input filtered);
    modport filter (input tick, input sample, input interval_code, output filtered);
endinterface

// ---- lfs_sync.sv ----
// Three-stage synchroniser that accepts a change once the last two stages agree.
`timescale 1ns/100ps
module lfs_sync (
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Asynchronous input and synchronised level.
    input wire logic i_async,
    output logic o_level
);
    logic meta_q;
    logic s2_q;
    logic s3_q;
    logic level_q;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            meta_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            meta_q <= i_async;
            s2_q <= meta_q;
            s3_q <= s2_q;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            level_q <= 1'b0;
        end else if (s2_q == s3_q) begin
            level_q <= s3_q;
        end
    end

    assign o_level = level_q;
endmodule

// ---- lfs_debounce.sv ----
// Ring-trip debounce filter counting interval steps of 1.25 ms.
`timescale 1ns/100ps
`include "lfs_params.svh"
module lfs_debounce
    import lfs_pkg::*;
(
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Link to the register bank.
    lfs_dbnc_if.filter dbnc
);
    lfs_db_state_t state_q;
    logic [`LFS_DEBOUNCE_W-1:0] count_q;
    logic filtered_q;

    // The first step tick after a change may come early, so code plus one ticks are counted.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            state_q <= LFS_DB_STEADY;
            count_q <= '0;
            filtered_q <= 1'b0;
        end else begin
            case (state_q)
                LFS_DB_STEADY: begin
                    count_q <= '0;
                    if (dbnc.sample != filtered_q) begin
                        if (dbnc.interval_code == '0) begin
                            filtered_q <= dbnc.sample;
                        end else begin
                            state_q <= LFS_DB_TIMING;
                        end
                    end
                end
                LFS_DB_TIMING: begin
                    if (dbnc.sample == filtered_q) begin
                        state_q <= LFS_DB_STEADY;
                        count_q <= '0;
                    end else if (dbnc.tick) begin
                        if (count_q >= dbnc.interval_code) begin
                            filtered_q <= dbnc.sample;
                            state_q <= LFS_DB_STEADY;
                            count_q <= '0;
                        end else begin
                            count_q <= count_q + 1'b1;
                        end
                    end
                end
                default: begin
                    state_q <= LFS_DB_STEADY;
                    count_q <= '0;
                end
            endcase
        end
    end

    assign dbnc.filtered = filtered_q;
endmodule

// ---- lfs_top.sv ----
// Line-feed setpoint register bank with ring-trip debounce and interrupt.
`timescale 1ns/100ps
`include "lfs_params.svh"
module lfs_top
    import lfs_pkg::*;
#(
    parameter int P_STEP_CYCLES = `LFS_DEBOUNCE_STEP_CYCLES
) (
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Register port.
    input wire logic [`LFS_ADDR_W-1:0] i_addr,
    input wire logic [`LFS_DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [`LFS_DATA_W-1:0] o_rdata,
    // Line inputs.
    input wire logic i_ring_trip_raw,
    input wire lfs_line_state_t i_line_state,
    // Feed current and battery codes.
    output logic [`LFS_CURRENT_W-1:0] o_feed_current_code,
    output logic [`LFS_VOLT_W-1:0] o_high_battery_code,
    // Differential voltage control.
    output logic [`LFS_VOLT_W-1:0] o_on_hook_voltage_code,
    output logic o_on_hook_polarity,
    output logic o_diff_force,
    // Common-mode control.
    output logic [`LFS_VOLT_W-1:0] o_common_mode_code,
    output logic o_cm_on_tip,
    output logic o_cm_on_ring,
    output logic o_cm_force_tip,
    output logic o_cm_force_ring,
    // Status and interrupt.
    output logic o_ring_trip_flag,
    output logic o_irq
);
    ////////////////////////////////////////////////////////////////////////////////
    logic [`LFS_DEBOUNCE_W-1:0] debounce_q;
    logic [`LFS_CURRENT_W-1:0] current_q;
    logic polarity_q;
    logic [`LFS_VOLT_W-1:0] on_hook_q;
    logic [`LFS_VOLT_W-1:0] common_mode_q;
    logic [`LFS_VOLT_W-1:0] high_battery_q;
    logic manual_cm_q;
    logic manual_diff_q;
    logic [`LFS_IRQ_W-1:0] irq_status_q;
    logic [`LFS_IRQ_W-1:0] irq_status_d;
    logic [`LFS_IRQ_W-1:0] irq_mask_q;
    logic [`LFS_IRQ_W-1:0] irq_events;
    logic [`LFS_IRQ_W-1:0] irq_clear;
    logic [`LFS_DATA_W-1:0] rdata_q;
    logic [`LFS_DATA_W-1:0] rdata_d;
    logic [31:0] div_q;
    logic tick_q;
    logic ring_trip_sync;
    logic filtered_prev_q;
    logic forward_state;
    logic reverse_state;

    lfs_dbnc_if dbnc ();

    ////////////////////////////////////////////////////////////////////////////////
    // Register writes; only the defined field bits are stored.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            debounce_q <= `LFS_RST_RT_DEBOUNCE;
        end else if (i_wr && i_addr == `LFS_OFS_RT_DEBOUNCE) begin
            debounce_q <= i_wdata[`LFS_DEBOUNCE_W-1:0];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            current_q <= `LFS_RST_FEED_CURRENT;
        end else if (i_wr && i_addr == `LFS_OFS_FEED_CURRENT) begin
            current_q <= i_wdata[`LFS_CURRENT_W-1:0];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            polarity_q <= `LFS_RST_POLARITY;
            on_hook_q <= `LFS_RST_ON_HOOK;
        end else if (i_wr && i_addr == `LFS_OFS_ON_HOOK) begin
            polarity_q <= i_wdata[`LFS_BIT_POLARITY];
            on_hook_q <= i_wdata[`LFS_VOLT_W-1:0];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            common_mode_q <= `LFS_RST_COMMON_MODE;
        end else if (i_wr && i_addr == `LFS_OFS_COMMON_MODE) begin
            common_mode_q <= i_wdata[`LFS_VOLT_W-1:0];
        end
    end

    // Ordering against the low battery setting is left to software.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            high_battery_q <= `LFS_RST_HIGH_BATTERY;
        end else if (i_wr && i_addr == `LFS_OFS_HIGH_BATTERY) begin
            high_battery_q <= i_wdata[`LFS_VOLT_W-1:0];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            manual_cm_q <= `LFS_RST_MANUAL;
            manual_diff_q <= `LFS_RST_MANUAL;
        end else if (i_wr && i_addr == `LFS_OFS_MANUAL_CTL) begin
            manual_cm_q <= i_wdata[`LFS_BIT_MANUAL_CM];
            manual_diff_q <= i_wdata[`LFS_BIT_MANUAL_DIFF];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            irq_mask_q <= `LFS_RST_IRQ;
        end else if (i_wr && i_addr == `LFS_OFS_IRQ_MASK) begin
            irq_mask_q <= i_wdata[`LFS_IRQ_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Step divider giving a one-cycle tick every debounce step.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            div_q <= '0;
            tick_q <= 1'b0;
        end else if (div_q >= 32'(P_STEP_CYCLES - 1)) begin
            div_q <= '0;
            tick_q <= 1'b1;
        end else begin
            div_q <= div_q + 32'h0000_0001;
            tick_q <= 1'b0;
        end
    end

    lfs_sync u_sync (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_async(i_ring_trip_raw),
        .o_level(ring_trip_sync)
    );

    assign dbnc.tick = tick_q;
    assign dbnc.sample = ring_trip_sync;
    assign dbnc.interval_code = debounce_q;

    lfs_debounce u_debounce (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .dbnc(dbnc)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Ring-trip edges set sticky status bits; a new event wins over a clear.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            filtered_prev_q <= 1'b0;
        end else begin
            filtered_prev_q <= dbnc.filtered;
        end
    end

    always_comb begin
        irq_events = '0;
        irq_events[`LFS_IRQ_DETECT] = dbnc.filtered && !filtered_prev_q;
        irq_events[`LFS_IRQ_RELEASE] = !dbnc.filtered && filtered_prev_q;
        irq_clear = '0;
        if (i_wr && i_addr == `LFS_OFS_IRQ_STATUS) begin
            irq_clear = i_wdata[`LFS_IRQ_W-1:0];
        end
        irq_status_d = (irq_status_q & ~irq_clear) | irq_events;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            irq_status_q <= `LFS_RST_IRQ;
        end else begin
            irq_status_q <= irq_status_d;
        end
    end

    assign o_irq = |(irq_status_q & irq_mask_q);

    ////////////////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the strobe; unmapped and reserved bits read zero.
    always_comb begin
        rdata_d = '0;
        if (i_rd) begin
            case (i_addr)
                `LFS_OFS_RT_DEBOUNCE: rdata_d[`LFS_DEBOUNCE_W-1:0] = debounce_q;
                `LFS_OFS_FEED_CURRENT: rdata_d[`LFS_CURRENT_W-1:0] = current_q;
                `LFS_OFS_ON_HOOK: begin
                    rdata_d[`LFS_BIT_POLARITY] = polarity_q;
                    rdata_d[`LFS_VOLT_W-1:0] = on_hook_q;
                end
                `LFS_OFS_COMMON_MODE: rdata_d[`LFS_VOLT_W-1:0] = common_mode_q;
                `LFS_OFS_HIGH_BATTERY: rdata_d[`LFS_VOLT_W-1:0] = high_battery_q;
                `LFS_OFS_MANUAL_CTL: begin
                    rdata_d[`LFS_BIT_MANUAL_CM] = manual_cm_q;
                    rdata_d[`LFS_BIT_MANUAL_DIFF] = manual_diff_q;
                end
                `LFS_OFS_LINE_STATUS: rdata_d[`LFS_BIT_RING_TRIP] = dbnc.filtered;
                `LFS_OFS_IRQ_STATUS: rdata_d[`LFS_IRQ_W-1:0] = irq_status_q;
                `LFS_OFS_IRQ_MASK: rdata_d[`LFS_IRQ_W-1:0] = irq_mask_q;
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign o_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Analog control codes.
    always_comb begin
        forward_state = (i_line_state == LFS_LS_FWD_ACTIVE) || (i_line_state == LFS_LS_FWD_ON_HOOK);
        reverse_state = (i_line_state == LFS_LS_REV_ACTIVE) || (i_line_state == LFS_LS_REV_ON_HOOK);
    end

    assign o_feed_current_code = current_q;
    assign o_high_battery_code = high_battery_q;
    assign o_on_hook_voltage_code = on_hook_q;
    assign o_on_hook_polarity = polarity_q;
    assign o_diff_force = manual_diff_q;
    assign o_common_mode_code = common_mode_q;
    assign o_cm_on_tip = forward_state;
    assign o_cm_on_ring = reverse_state;
    assign o_cm_force_tip = manual_cm_q && forward_state;
    assign o_cm_force_ring = manual_cm_q && reverse_state;
    assign o_ring_trip_flag = dbnc.filtered;
endmodule

// ---- lfs_assertions.sv ----
// Port checks for the line-feed setpoint register bank.
`timescale 1ns/100ps
`include "lfs_params.svh"
module lfs_assertions
    import lfs_pkg::*;
#(
    parameter int P_STEP_CYCLES = 4
) (
    // Clock and reset.
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Register port.
    input wire logic [`LFS_ADDR_W-1:0] i_addr,
    input wire logic [`LFS_DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [`LFS_DATA_W-1:0] o_rdata,
    // Line side.
    input wire logic i_ring_trip_raw,
    input wire lfs_line_state_t i_line_state,
    input wire logic [`LFS_CURRENT_W-1:0] o_feed_current_code,
    input wire logic [`LFS_VOLT_W-1:0] o_high_battery_code,
    input wire logic [`LFS_VOLT_W-1:0] o_on_hook_voltage_code,
    input wire logic o_on_hook_polarity,
    input wire logic o_diff_force,
    input wire logic [`LFS_VOLT_W-1:0] o_common_mode_code,
    input wire logic o_cm_on_tip,
    input wire logic o_cm_on_ring,
    input wire logic o_cm_force_tip,
    input wire logic o_cm_force_ring,
    input wire logic o_ring_trip_flag,
    input wire logic o_irq
);
    logic [7:0] wd_q;
    always_ff @(posedge i_core_clk) begin
        wd_q <= i_wdata;
    end
    // Cycles since the raw ring-trip input was last seen high, saturating.
    logic [2:0] raw_idle_q;
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            raw_idle_q <= 3'h7;
        end else if (i_ring_trip_raw) begin
            raw_idle_q <= 3'h0;
        end else if (raw_idle_q != 3'h7) begin
            raw_idle_q <= raw_idle_q + 3'h1;
        end
    end
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    ////////////////////////////////////////
    a_rdata_idle_zero: assert property (!i_rd |=> o_rdata == 8'h00)
        else $error("read data not zero when idle");
    a_feed_write_lands: assert property (i_wr && i_addr == 8'h47 |=> o_feed_current_code == wd_q[2:0])
        else $error("feed current code not updated");
    a_onhook_write_lands: assert property (i_wr && i_addr == 8'h48 |=>
        {o_on_hook_polarity, o_on_hook_voltage_code} == wd_q[6:0])
        else $error("on-hook code or polarity not updated");
    a_cm_write_lands: assert property (i_wr && i_addr == 8'h49 |=> o_common_mode_code == wd_q[5:0])
        else $error("common-mode code not updated");
    a_hbat_write_lands: assert property (i_wr && i_addr == 8'h4A |=> o_high_battery_code == wd_q[5:0])
        else $error("high battery code not updated");
    a_cm_side_select: assert property (o_cm_on_tip == (i_line_state inside {LFS_LS_FWD_ACTIVE, LFS_LS_FWD_ON_HOOK})
        && o_cm_on_ring == (i_line_state inside {LFS_LS_REV_ACTIVE, LFS_LS_REV_ON_HOOK}))
        else $error("common-mode side wrong for line state");
    a_force_needs_side: assert property ((!o_cm_force_tip || o_cm_on_tip) && (!o_cm_force_ring || o_cm_on_ring))
        else $error("common-mode force on wrong conductor");
    a_reset_defaults_out: assert property ($past(i_rst) |-> o_on_hook_voltage_code == 6'h20
        && o_common_mode_code == 6'h02 && o_high_battery_code == 6'h32 && o_feed_current_code == 3'h0)
        else $error("codes not at defaults after reset");
    a_flag_needs_raw: assert property ($rose(o_ring_trip_flag) |-> raw_idle_q <= 3'h4)
        else $error("ring trip flag rose without raw input");
    a_rd_reserved_zero: assert property (i_rd && i_addr inside {8'h49, 8'h4A} |=> o_rdata[7:6] == 2'b00)
        else $error("reserved read bits not zero");
    cover property ($rose(o_ring_trip_flag));
    cover property ($rose(o_irq));
    cover property (i_wr ##1 i_rd);
endmodule

bind lfs_top lfs_assertions #(.P_STEP_CYCLES(P_STEP_CYCLES)) u_chk (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_ring_trip_raw(i_ring_trip_raw), .i_line_state(i_line_state), .o_feed_current_code(o_feed_current_code),
    .o_high_battery_code(o_high_battery_code), .o_on_hook_voltage_code(o_on_hook_voltage_code),
    .o_on_hook_polarity(o_on_hook_polarity), .o_diff_force(o_diff_force), .o_common_mode_code(o_common_mode_code),
    .o_cm_on_tip(o_cm_on_tip), .o_cm_on_ring(o_cm_on_ring), .o_cm_force_tip(o_cm_force_tip),
    .o_cm_force_ring(o_cm_force_ring), .o_ring_trip_flag(o_ring_trip_flag), .o_irq(o_irq));

// ---- tb_top.sv ----
// Self-checking bench for the line-feed setpoint register bank.
`timescale 1ns/100ps
module tb_top
    import lfs_pkg::*;
;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_ring_trip_raw = 1'b0;
    lfs_line_state_t i_line_state = LFS_LS_OPEN;
    logic [7:0] o_rdata;
    logic [2:0] o_feed_current_code;
    logic [5:0] o_high_battery_code;
    logic [5:0] o_on_hook_voltage_code;
    logic [5:0] o_common_mode_code;
    logic o_on_hook_polarity;
    logic o_diff_force;
    logic o_cm_on_tip;
    logic o_cm_on_ring;
    logic o_cm_force_tip;
    logic o_cm_force_ring;
    logic o_ring_trip_flag;
    logic o_irq;
    int mismatches = 0;
    int n_compared = 0;
    logic [7:0] m [5];
    localparam logic [7:0] MSK [5] = '{8'h7F, 8'h07, 8'h7F, 8'h3F, 8'h3F};
    localparam logic [7:0] RST [5] = '{8'h0A, 8'h00, 8'h20, 8'h02, 8'h32};

    always #5 i_core_clk = ~i_core_clk;

    lfs_top #(.P_STEP_CYCLES(4)) dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ring_trip_raw(i_ring_trip_raw),
        .i_line_state(i_line_state), .o_feed_current_code(o_feed_current_code),
        .o_high_battery_code(o_high_battery_code), .o_on_hook_voltage_code(o_on_hook_voltage_code),
        .o_on_hook_polarity(o_on_hook_polarity), .o_diff_force(o_diff_force),
        .o_common_mode_code(o_common_mode_code), .o_cm_on_tip(o_cm_on_tip), .o_cm_on_ring(o_cm_on_ring),
        .o_cm_force_tip(o_cm_force_tip), .o_cm_force_ring(o_cm_force_ring),
        .o_ring_trip_flag(o_ring_trip_flag), .o_irq(o_irq));

    ////////////////////////////////////////
    function automatic logic [7:0] fw(int k, int r);
        return (k == 1 + 2 * r || k == 2 + 2 * r) ? 8'h01 : 8'h00;
    endfunction

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
        @(posedge i_core_clk);
    endtask

    task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1;
        chk(nm, e, o_rdata);
        @(posedge i_core_clk);
    endtask

    task automatic outs;
        @(negedge i_core_clk);
        chk("feed", m[1], {5'h00, o_feed_current_code});
        chk("onhook", m[2], {1'b0, o_on_hook_polarity, o_on_hook_voltage_code});
        chk("cm", m[3], {2'b00, o_common_mode_code});
        chk("hbat", m[4], {2'b00, o_high_battery_code});
        @(posedge i_core_clk);
    endtask

    task automatic ic(input logic [7:0] e);
        @(negedge i_core_clk);
        chk("irq", e, {7'h00, o_irq});
        @(posedge i_core_clk);
    endtask

    task automatic wait_flag(input logic v, output int n);
        n = 0;
        @(negedge i_core_clk);
        while (o_ring_trip_flag !== v) begin
            if (n > 2000) begin
                mismatches++;
                close_out();
            end
            @(negedge i_core_clk);
            n++;
        end
        @(posedge i_core_clk);
    endtask

    ////////////////////////////////////////
    initial begin
        int k;
        int n;
        logic [7:0] d;
        d = $urandom(32'h174a);
        repeat (2) @(posedge i_core_clk);
        i_rst <= 1'b0;
        for (k = 0; k < 5; k++) begin
            m[k] = RST[k];
            rdc("reset", 8'h46 + k, RST[k]);
        end
        outs();
        for (k = 0; k < 45; k++) begin
            n = (k < 5) ? k : $urandom % 5;
            d = (k < 5) ? 8'hFF : $urandom;
            wr(8'h46 + n, d);
            m[n] = d & MSK[n];
            rdc("reg", 8'h46 + n, m[n]);
            outs();
        end
        i_rst <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        i_rst <= 1'b0;
        for (k = 0; k < 5; k++) begin
            m[k] = RST[k];
            rdc("rereset", 8'h46 + k, RST[k]);
        end
        outs();
        wr(8'h4A, 8'h32);
        m[4] = 8'h32;
        wr(8'h60, 8'hA5);
        rdc("unmapped", 8'h60, 8'h00);
        wr(8'h44, 8'hFF);
        rdc("status", 8'h44, 8'h00);
        wr(8'h43, 8'hE0);
        rdc("manual", 8'h43, 8'h60);
        for (n = 1; n >= 0; n--) begin
            wr(8'h43, n ? 8'h60 : 8'h00);
            for (k = 0; k < 5; k++) begin
                i_line_state <= lfs_line_state_t'(k);
                @(negedge i_core_clk);
                chk("tip", fw(k, 0), {7'h00, o_cm_on_tip});
                chk("ring", fw(k, 1), {7'h00, o_cm_on_ring});
                chk("ftip", fw(k, 0) & n, {7'h00, o_cm_force_tip});
                chk("fring", fw(k, 1) & n, {7'h00, o_cm_force_ring});
                chk("diff", 8'(n), {7'h00, o_diff_force});
                @(posedge i_core_clk);
            end
        end
        wr(8'h51, 8'h01);
        wr(8'h46, 8'h02);
        i_ring_trip_raw <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        i_ring_trip_raw <= 1'b0;
        repeat (40) @(posedge i_core_clk);
        rdc("glitch", 8'h50, 8'h00);
        i_ring_trip_raw <= 1'b1;
        wait_flag(1'b1, n);
        chk("delay", 8'h01, {7'h00, n >= 12 && n <= 24});
        rdc("status", 8'h44, 8'h02);
        rdc("irqst", 8'h50, 8'h01);
        ic(8'h01);
        wr(8'h50, 8'h01);
        rdc("irqclr", 8'h50, 8'h00);
        ic(8'h00);
        i_ring_trip_raw <= 1'b0;
        wait_flag(1'b0, n);
        rdc("irqrel", 8'h50, 8'h02);
        ic(8'h00);
        wr(8'h50, 8'h02);
        wr(8'h46, 8'h00);
        i_ring_trip_raw <= 1'b1;
        wait_flag(1'b1, n);
        chk("nodelay", 8'h01, {7'h00, n <= 8});
        ic(8'h01);
        rdc("mask", 8'h51, 8'h01);
        close_out();
    end
endmodule
